// ===== design/fwsr_host.sv
// Overview of operation
// - Chip select and output enable together frame reads
// - Host queues reset command in write data after timeout
// - Host rechecks toggling when error bit set
// - Host combines toggle and sector toggle bits
// - Host reads twice and compares toggle
// - Still toggling with error means fail, reset
// - Restart polling from double read after abandon
`timescale 1ns/100ps
`default_nettype none
module fwsr_host (
   input  wire logic                        clock_i,
   input  wire logic                        rstn_i,
   input  wire logic [3:0]                  reg_addr_i,
   input  wire logic [15:0]                 reg_wdata_i,
   input  wire logic                        reg_wr_i,
   input  wire logic                        reg_rd_i,
   output logic      [15:0]                 reg_rdata_o,
   output logic      [fwsr_pkg::ADDR_W-1:0] flash_addr_o,
   output logic      [fwsr_pkg::DATA_W-1:0] flash_dq_o,
   output logic                             flash_dq_oe_o,
   input  wire logic [fwsr_pkg::DATA_W-1:0] flash_dq_i,
   output logic                             flash_ce_n_o,
   output logic                             flash_oe_n_o,
   output logic                             flash_we_n_o,
   input  wire logic                        ready_busy_n_i
);
   fwsr_pkg::fwsr_state_type state_r;
   logic [fwsr_pkg::DATA_W-1:0] dq_sync;
   logic                        dev_busy_sync;
   logic [fwsr_pkg::ADDR_W-1:0] addr_r;
   logic [15:0]                 wdata_r;
   logic [15:0]                 rdata_r;
   logic [15:0]                 last_r;
   logic [2:0]                  cnt_r;
   logic                        polling_r;
   logic                        have_first_r;
   logic                        err_seen_r;
   logic [1:0]                  result_r;
   logic                        busy;
   logic                        sect_tog_r;
   logic                        tog_moved;
   logic                        sect_moved;
   logic                        fail_now;

   // Data pins and ready/busy are asynchronous to our clock
   fwsr_sync #(.W(fwsr_pkg::DATA_W + 1)) u_sync (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      // Busy travels in true polarity so the reset value reads as not busy
      .d_i     ({~ready_busy_n_i, flash_dq_i}),
      .q_o     ({dev_busy_sync, dq_sync})
   );

   assign busy = (state_r != fwsr_pkg::ST_IDLE);

   // Compare the newest sample with the one before it
   assign tog_moved  = rdata_r[fwsr_pkg::TOGGLE_BIT] != last_r[fwsr_pkg::TOGGLE_BIT];
   assign sect_moved = rdata_r[fwsr_pkg::SECT_TOGGLE_BIT] !=
                       last_r[fwsr_pkg::SECT_TOGGLE_BIT];
   // Still toggling after the error bit: give up and queue the reset command
   assign fail_now   = state_r == fwsr_pkg::ST_EVAL && polling_r && have_first_r &&
                       err_seen_r && tog_moved;

   // Register writes
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         addr_r  <= '0;
         wdata_r <= '0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == fwsr_pkg::REG_ADDR) begin
            addr_r <= {3'h0, reg_wdata_i};
         end else if (reg_addr_i == fwsr_pkg::REG_WDATA) begin
            wdata_r <= reg_wdata_i;
         end
      end else if (fail_now) begin
         wdata_r <= fwsr_pkg::RESET_CMD;
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         if (reg_addr_i == fwsr_pkg::REG_ADDR) begin
            reg_rdata_o <= addr_r[15:0];
         end else if (reg_addr_i == fwsr_pkg::REG_WDATA) begin
            reg_rdata_o <= wdata_r;
         end else if (reg_addr_i == fwsr_pkg::REG_STATUS) begin
            reg_rdata_o <= {9'h000, sect_tog_r, dev_busy_sync, err_seen_r, polling_r,
                            result_r, busy};
         end else if (reg_addr_i == fwsr_pkg::REG_RDATA) begin
            reg_rdata_o <= rdata_r;
         end else if (reg_addr_i == fwsr_pkg::REG_LAST) begin
            reg_rdata_o <= last_r;
         end else begin
            reg_rdata_o <= '0;
         end
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // Bus sequencer
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= fwsr_pkg::ST_IDLE;
         cnt_r   <= '0;
      end else begin
         case (state_r)
            fwsr_pkg::ST_IDLE: begin
               cnt_r <= 3'(fwsr_pkg::STROBE_CYC + 2);
               if (reg_wr_i && reg_addr_i == fwsr_pkg::REG_CTRL) begin
                  if (reg_wdata_i[fwsr_pkg::CMD_WRITE]) begin
                     state_r <= fwsr_pkg::ST_WRITE;
                  end else if (reg_wdata_i[fwsr_pkg::CMD_READ] ||
                               reg_wdata_i[fwsr_pkg::CMD_POLL]) begin
                     state_r <= fwsr_pkg::ST_READ;
                  end
               end
            end
            fwsr_pkg::ST_READ: begin
               // Hold strobe through the sync delay so the sample is settled
               if (cnt_r == 3'h0) begin
                  state_r <= fwsr_pkg::ST_GAP;
                  cnt_r   <= 3'(fwsr_pkg::GAP_CYC);
               end else begin
                  cnt_r <= cnt_r - 3'h1;
               end
            end
            fwsr_pkg::ST_WRITE: begin
               if (cnt_r == 3'h0) begin
                  state_r <= fwsr_pkg::ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 3'h1;
               end
            end
            fwsr_pkg::ST_GAP: begin
               // Rising strobe ends the read cycle; device advances toggle here
               if (cnt_r == 3'h0) begin
                  state_r <= polling_r ? fwsr_pkg::ST_EVAL : fwsr_pkg::ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 3'h1;
               end
            end
            fwsr_pkg::ST_EVAL: begin
               state_r <= (result_r == fwsr_pkg::RES_NONE && polling_r) ?
                          fwsr_pkg::ST_IDLE : fwsr_pkg::ST_IDLE;
            end
            default: state_r <= fwsr_pkg::ST_IDLE;
         endcase
      end
   end

   // Pin drive
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flash_addr_o  <= '0;
         flash_dq_o    <= '0;
         flash_dq_oe_o <= 1'b0;
         flash_ce_n_o  <= 1'b1;
         flash_oe_n_o  <= 1'b1;
         flash_we_n_o  <= 1'b1;
      end else begin
         flash_addr_o  <= addr_r;
         flash_dq_o    <= wdata_r;
         flash_dq_oe_o <= (state_r == fwsr_pkg::ST_WRITE);
         flash_ce_n_o  <= !(state_r == fwsr_pkg::ST_WRITE || state_r == fwsr_pkg::ST_READ);
         // Both strobes pulse per read, either one would advance the toggle
         flash_oe_n_o  <= !(state_r == fwsr_pkg::ST_READ);
         flash_we_n_o  <= !(state_r == fwsr_pkg::ST_WRITE && cnt_r != 3'h0);
      end
   end

   // Toggle polling procedure
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         polling_r    <= 1'b0;
         have_first_r <= 1'b0;
         err_seen_r   <= 1'b0;
         result_r     <= fwsr_pkg::RES_NONE;
         rdata_r      <= '0;
         last_r       <= '0;
         sect_tog_r   <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == fwsr_pkg::REG_CTRL &&
                   (reg_wdata_i[fwsr_pkg::CMD_ABORT] ||
                    (reg_wdata_i[fwsr_pkg::CMD_POLL] && !busy))) begin
         // Abandon or restart always begins with a fresh double read
         polling_r    <= reg_wdata_i[fwsr_pkg::CMD_POLL] && !reg_wdata_i[fwsr_pkg::CMD_ABORT];
         have_first_r <= 1'b0;
         sect_tog_r   <= 1'b0;
         err_seen_r   <= 1'b0;
         result_r     <= fwsr_pkg::RES_NONE;
      end else if (state_r == fwsr_pkg::ST_GAP && cnt_r == 3'(fwsr_pkg::GAP_CYC)) begin
         rdata_r <= dq_sync;
      end else if (state_r == fwsr_pkg::ST_EVAL) begin
         last_r       <= rdata_r;
         have_first_r <= 1'b1;
         if (have_first_r) begin
            // Sector toggle picks the sector, main toggle tells erase from suspend
            sect_tog_r <= sect_moved;
            if (rdata_r[fwsr_pkg::TOGGLE_BIT] == last_r[fwsr_pkg::TOGGLE_BIT]) begin
               result_r  <= fwsr_pkg::RES_DONE;
               polling_r <= 1'b0;
            end else if (err_seen_r) begin
               result_r  <= fwsr_pkg::RES_FAIL;
               polling_r <= 1'b0;
            end else if (rdata_r[fwsr_pkg::TIMEOUT_BIT]) begin
               err_seen_r <= 1'b1;
            end
         end
      end
   end
endmodule // fwsr_host
`default_nettype wire

// ===== design/fwsr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module fwsr_sync #(
   parameter int W = 1
) (
   input  wire logic         clock_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule // fwsr_sync
`default_nettype wire

// ===== pkg/fwsr_pkg.sv
package fwsr_pkg;
   localparam int        DATA_W          = 16;
   localparam int        ADDR_W          = 19;
   // Status bit positions on the data bus
   localparam int        POLL_BIT        = 7;
   localparam int        TOGGLE_BIT      = 6;
   localparam int        TIMEOUT_BIT     = 5;
   localparam int        TIMER_BIT       = 3;
   localparam int        SECT_TOGGLE_BIT = 2;
   // Controller register offsets
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_ADDR       = 4'h1;
   localparam logic [3:0] REG_WDATA      = 4'h2;
   localparam logic [3:0] REG_STATUS     = 4'h3;
   localparam logic [3:0] REG_RDATA      = 4'h4;
   localparam logic [3:0] REG_LAST       = 4'h5;
   // Control command bits
   localparam int        CMD_READ        = 0;
   localparam int        CMD_WRITE       = 1;
   localparam int        CMD_POLL        = 2;
   localparam int        CMD_ABORT       = 3;
   // Reset command value
   localparam logic [15:0] RESET_CMD     = 16'h00F0;
   // Bus timing in cycles of 100 ns
   localparam int        CLK_NS          = 100;
   localparam int        STROBE_NS       = 100;
   localparam int        STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int        GAP_NS          = 100;
   localparam int        GAP_CYC         = (GAP_NS + CLK_NS - 1) / CLK_NS;
   // Poll result codes
   localparam logic [1:0] RES_NONE       = 2'h0;
   localparam logic [1:0] RES_DONE       = 2'h1;
   localparam logic [1:0] RES_FAIL       = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_READ  = 3'b001,
      ST_WRITE = 3'b010,
      ST_GAP   = 3'b011,
      ST_EVAL  = 3'b100
   } fwsr_state_type;
endpackage

// ===== tb/fwsr_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fwsr_flash_model #(
   parameter logic [15:0] ARRAY_WORD   = 16'h00A5,
   // Stand-in code for the suspend command
   parameter logic [15:0] SUSPEND_WORD = 16'h00EE
) (
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        host_oe_i,
   input  wire logic [15:0] host_dq_i,
   input  wire logic        busy_i,
   input  wire logic        err_i,
   input  wire logic        erase_i,
   input  wire logic        susp_i,
   input  wire logic        in_sect_i,
   output logic      [15:0] bus_o,
   output logic      [15:0] last_cmd_o,
   output logic             ready_busy_n_o
);
   logic        tog_r = 1'b0;
   logic        tog2_r = 1'b0;
   logic [15:0] stat;
   wire         rd = !ce_n_i && !oe_n_i;
   initial last_cmd_o = 16'h0000;
   // Either strobe ends the read cycle
   always @(negedge rd) if (busy_i) tog_r <= ~tog_r;
   // Second toggle moves only in sectors picked for erase, running or suspended
   always @(negedge rd)
      if (in_sect_i && ((busy_i && erase_i) || susp_i)) tog2_r <= ~tog2_r;
   // Program status: timer and sector toggle bits do not apply
   always_comb begin
      if (busy_i && !erase_i) begin
         stat = {8'h00, ~ARRAY_WORD[7], tog_r, err_i, 5'h00};
      end else if (busy_i) begin
         stat = {8'h00, 1'b0, tog_r, err_i, 1'b0, 1'b1, tog2_r, 2'b00};
      end else if (susp_i && in_sect_i) begin
         stat = {8'h00, 1'b1, tog_r, 3'b000, tog2_r, 2'b00};
      end else begin
         stat = ARRAY_WORD;
      end
   end
   // Released bus shows inverted data so a stale value cannot pass
   assign bus_o = rd ? stat : (host_oe_i ? host_dq_i : ~stat);
   // While erasing only the suspend word gets through
   always @(posedge we_n_i)
      if (!(busy_i && erase_i) || host_dq_i == SUSPEND_WORD) last_cmd_o <= host_dq_i;
   assign ready_busy_n_o = ~busy_i;
endmodule // fwsr_flash_model
`default_nettype wire

// ===== tb/fwsr_host_properties.sv
`timescale 1ns/100ps
`default_nettype none
module fwsr_host_properties (
   input wire logic        clock_i,
   input wire logic        rstn_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic [15:0] flash_dq_o,
   input wire logic        flash_dq_oe_o,
   input wire logic        flash_ce_n_o,
   input wire logic        flash_oe_n_o,
   input wire logic        flash_we_n_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   chk_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside its cycle");
   chk_read_frame: assert property ($fell(flash_oe_n_o) |-> !flash_ce_n_o && flash_we_n_o)
      else $error("read strobe without chip select");
   chk_read_width: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o[*4] ##1 flash_oe_n_o)
      else $error("read strobe length wrong");
   chk_no_fight: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
      else $error("host drives bus during read");
   chk_write_width: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o[*3] ##1 flash_we_n_o)
      else $error("write strobe length wrong");
   chk_write_data: assert property ($fell(flash_we_n_o) |=> (flash_dq_oe_o && $stable(flash_dq_o))[*2])
      else $error("write data not held");
   chk_one_strobe: assert property (flash_we_n_o || flash_oe_n_o)
      else $error("read and write strobes together");
   cov_read: cover property ($fell(flash_oe_n_o));
   cov_write: cover property ($fell(flash_we_n_o));
   cov_rdata: cover property (reg_rd_i ##1 reg_rdata_o != 16'h0000);
endmodule // fwsr_host_properties
bind fwsr_host fwsr_host_properties chk_u (.*);
`default_nettype wire

// ===== tb/fwsr_host_test.sv
`timescale 1ns/100ps
`default_nettype none
module fwsr_host_test;
   localparam logic [15:0] ARR = 16'h00A5;
   localparam logic [15:0] SUSP = 16'h00EE;
   logic clock_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, busy = 0, err = 0;
   logic        erase = 0, susp = 0, in_sect = 0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000, rdata, st, bus, last_cmd;
   logic [18:0] faddr;
   logic [15:0] fdq;
   logic        fdq_oe, ce_n, oe_n, we_n, rb_n;
   int          err_count = 0, checks_done = 0;
   always #50 clock_i = ~clock_i;
   fwsr_host dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(rdata), .flash_addr_o(faddr), .flash_dq_o(fdq), .flash_dq_oe_o(fdq_oe),
      .flash_dq_i(bus), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
      .ready_busy_n_i(rb_n));
   fwsr_flash_model #(.ARRAY_WORD(ARR), .SUSPEND_WORD(SUSP)) dev_u (.ce_n_i(ce_n),
      .oe_n_i(oe_n), .we_n_i(we_n), .host_oe_i(fdq_oe), .host_dq_i(fdq), .busy_i(busy),
      .err_i(err), .erase_i(erase), .susp_i(susp), .in_sect_i(in_sect), .bus_o(bus),
      .last_cmd_o(last_cmd), .ready_busy_n_o(rb_n));
   task automatic end_sim();
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      reg_rd_i <= 1'b1; reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 d = rdata;
   endtask
   // Bounded wait on the busy flag; a hang ends the run
   task automatic wait_idle();
      for (int i = 0; i < 40; i++) begin
         rd(fwsr_pkg::REG_STATUS, st);
         if (st[0] === 1'b0) return;
      end
      err_count++;
      $display("[ERR] %0t controller stuck busy", $time);
      end_sim();
   endtask
   // Issue single reads until the poll verdict appears, at most four
   task automatic poll_until(input logic [1:0] res);
      for (int i = 0; i < 4; i++) begin
         wr(fwsr_pkg::REG_CTRL, 16'h0001);
         wait_idle();
         if (st[2:1] === res) return;
      end
   endtask
   initial begin
      repeat (5) @(posedge clock_i);
      rstn_i <= 1'b1;
      rd(fwsr_pkg::REG_STATUS, st); cmp(st, 16'h0000);
      rd(fwsr_pkg::REG_RDATA, st); cmp(st, 16'h0000);
      wr(fwsr_pkg::REG_CTRL, 16'h0002); wait_idle();
      busy <= 1'b1;
      wr(fwsr_pkg::REG_CTRL, 16'h0004); wait_idle();
      cmp(st & 16'h0020, 16'h0020);
      wr(fwsr_pkg::REG_CTRL, 16'h0001); wait_idle();
      cmp(st & 16'h0006, 16'h0000);
      busy <= 1'b0;
      poll_until(fwsr_pkg::RES_DONE);
      cmp(st & 16'h0026, 16'h0002);
      rd(fwsr_pkg::REG_RDATA, st); cmp(st, ARR);
      rd(fwsr_pkg::REG_LAST, st); cmp(st, ARR);
      busy <= 1'b1; err <= 1'b1;
      wr(fwsr_pkg::REG_CTRL, 16'h0004); wait_idle();
      poll_until(fwsr_pkg::RES_FAIL);
      cmp(st & 16'h0016, 16'h0014);
      rd(fwsr_pkg::REG_WDATA, st); cmp(st, fwsr_pkg::RESET_CMD);
      wr(fwsr_pkg::REG_CTRL, 16'h0002); wait_idle();
      cmp(last_cmd, fwsr_pkg::RESET_CMD);
      // Sector erase: poll, abandon, restart, then suspend inside the sector
      busy <= 1'b0; err <= 1'b0; erase <= 1'b1; in_sect <= 1'b1;
      wr(fwsr_pkg::REG_ADDR, 16'h1234);
      rd(fwsr_pkg::REG_ADDR, st); cmp(st, 16'h1234);
      wr(fwsr_pkg::REG_WDATA, 16'h0030);
      wr(fwsr_pkg::REG_CTRL, 16'h0002); wait_idle();
      busy <= 1'b1;
      cmp(faddr[15:0], 16'h1234);
      cmp(16'(faddr[18:16]), 16'h0000);
      wr(fwsr_pkg::REG_CTRL, 16'h0004); wait_idle();
      wr(fwsr_pkg::REG_CTRL, 16'h0008); wait_idle();
      cmp(st & 16'h000E, 16'h0000);
      wr(fwsr_pkg::REG_CTRL, 16'h0004); wait_idle();
      cmp(st & 16'h0046, 16'h0000);
      rd(fwsr_pkg::REG_RDATA, st); cmp(st & 16'h0088, 16'h0008);
      wr(fwsr_pkg::REG_CTRL, 16'h0001); wait_idle();
      cmp(st & 16'h0066, 16'h0060);
      wr(fwsr_pkg::REG_WDATA, fwsr_pkg::RESET_CMD);
      wr(fwsr_pkg::REG_CTRL, 16'h0002); wait_idle();
      cmp(last_cmd, 16'h0030);
      wr(fwsr_pkg::REG_WDATA, SUSP);
      wr(fwsr_pkg::REG_CTRL, 16'h0002); wait_idle();
      cmp(last_cmd, SUSP);
      busy <= 1'b0; susp <= 1'b1;
      poll_until(fwsr_pkg::RES_DONE);
      cmp(st & 16'h0066, 16'h0042);
      rd(fwsr_pkg::REG_RDATA, st); cmp(st & 16'h0080, 16'h0080);
      in_sect <= 1'b0;
      wr(fwsr_pkg::REG_CTRL, 16'h0001); wait_idle();
      cmp(st & 16'h0020, 16'h0000);
      rd(fwsr_pkg::REG_RDATA, st); cmp(st, ARR);
      end_sim();
   end
endmodule // fwsr_host_test
`default_nettype wire
